// file: rtl/tmr_timer16.sv
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: Mode zero counts up always, no clear, wraps 0xFFFF to 0x0000.
// RQ2: Normal mode sets overflow flag as count becomes zero; counting never clears it.
// RQ3: Overflow flag clears when its interrupt is acknowledged.
// RQ4: Normal mode accepts a new count write at any time.
// RQ5: Clear-on-match top is compare A (mode 4) or capture (mode 12); clears on match.
// RQ6: Clear-on-match sets compare-A flag (mode 4) or capture flag (mode 12) at top.
// RQ7: Clear-on-match top is unbuffered; written below count, counter wraps first.
// RQ8: Clear-on-match with action 1 toggles output A on each match.
// RQ9: Output reaches pin only while its direction bit selects output.
// RQ10: Clear-on-match sets overflow flag as count passes max to zero.
// RQ11: Modes 5,6,7,14,15 count single-slope bottom to top then restart.
// RQ12: Fast PWM top is 0xFF, 0x1FF, 0x3FF, capture or compare A; clears after top.
// RQ13: Non-inverting clears on match, sets at bottom; inverting does the opposite.
// RQ14: Fast PWM sets overflow at top, plus compare-A or capture flag when defining top.
// RQ15: Fixed top masks compare register writes above the resolution.
// RQ16: Capture top is unbuffered; written below count, counter wraps before matching.
// RQ17: Fast PWM compare writes go to buffer, loaded at top with clear and overflow.
// RQ18: Fast PWM action 2 and 3 select opposite polarities; 3 is non-inverting here.
// RQ19: Software keeps register-defined top at least 0x0003.
// RQ20: Software keeps top at or above every compare register.
// RQ21: Channel compare flag sets whenever count equals its compare value.
// RQ22: Compare registers buffered in PWM modes, direct in normal and clear-on-match.
// RQ23: Action zero leaves the waveform register unchanged on match.
// RQ24: Count write blocks every compare match in the next timer clock cycle.
// RQ25: Counter advances only when the prescaler timer enable is high.
module tmr_timer16 (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                tick_en,
   input  wire logic                ovf_irq_ack,
   input  wire logic                capture_event,
   output tmr_pkg::tmr_pins_t       pins
);
   import tmr_pkg::*;

   tmr_ctrl_t   ctrl_reg;
   logic [15:0] count_reg;
   logic [15:0] cmp_a_reg;
   logic [15:0] cmp_b_reg;
   logic [15:0] buf_a_reg;
   logic [15:0] buf_b_reg;
   logic [15:0] capt_reg;
   logic [3:0]  flags_reg;
   logic        block_reg;
   logic        wave_a_reg;
   logic        wave_b_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   tmr_pins_t   pins_reg;
   logic        tick_meta;
   logic        tick_sync;
   logic        ack_meta;
   logic        ack_sync;
   logic        capt_meta;
   logic        capt_sync;
   logic        capt_prev;

   function automatic logic is_fast(input logic [3:0] m);
      is_fast = (m == MODE_FAST8) || (m == MODE_FAST9) || (m == MODE_FAST10) ||
                (m == MODE_FAST_CAP) || (m == MODE_FAST_CMP);
   endfunction

   function automatic logic [15:0] fixed_mask(input logic [3:0] m);
      if (m == MODE_FAST8) begin
         fixed_mask = TOP_FAST8;
      end else if (m == MODE_FAST9) begin
         fixed_mask = TOP_FAST9;
      end else if (m == MODE_FAST10) begin
         fixed_mask = TOP_FAST10;
      end else begin
         fixed_mask = TOP_MAX;
      end
   endfunction

   function automatic logic [6:0] reg_hit(input logic [11:0] a);
      reg_hit = 7'h00;
      if (a == ADDR_CTRL) begin
         reg_hit = 7'h01;
      end else if (a == ADDR_COUNT) begin
         reg_hit = 7'h02;
      end else if (a == ADDR_CMPA) begin
         reg_hit = 7'h04;
      end else if (a == ADDR_CMPB) begin
         reg_hit = 7'h08;
      end else if (a == ADDR_CAPT) begin
         reg_hit = 7'h10;
      end else if (a == ADDR_FLAGS) begin
         reg_hit = 7'h20;
      end else if (a == ADDR_ACTIVE) begin
         reg_hit = 7'h40;
      end
   endfunction

   function automatic logic next_wave(input logic cur, input logic fast, input logic [1:0] act,
                                      input logic match, input logic bottom);
      next_wave = cur;
      if (fast) begin
         if (match && act == ACT_CLEAR) begin
            next_wave = 1'b1; // RQ13 RQ18
         end else if (match && act == ACT_SET) begin
            next_wave = 1'b0; // RQ13 RQ18
         end else if (match && act == ACT_TOGGLE) begin
            next_wave = ~cur;
         end else if (bottom && act == ACT_CLEAR) begin
            next_wave = 1'b0; // RQ13
         end else if (bottom && act == ACT_SET) begin
            next_wave = 1'b1; // RQ13
         end
      end else if (match) begin
         if (act == ACT_TOGGLE) begin
            next_wave = ~cur; // RQ8
         end else if (act == ACT_CLEAR) begin
            next_wave = 1'b0;
         end else if (act == ACT_SET) begin
            next_wave = 1'b1;
         end
      end // RQ23
   endfunction

   // Bus decode.
   wire         acc_phase  = psel && penable && !pready_reg;
   wire         done_phase = psel && penable && pready_reg;
   wire  [6:0]  hit        = reg_hit(paddr);
   wire         wr_en      = done_phase && pwrite && (pstrb[1:0] == 2'b11);
   wire         wr_ctrl    = wr_en && hit[0];
   wire         wr_count   = wr_en && hit[1];
   wire         wr_cmpa    = wr_en && hit[2];
   wire         wr_cmpb    = wr_en && hit[3];
   wire         wr_capt    = wr_en && hit[4];
   wire         wr_flags   = wr_en && hit[5];
   wire         addr_ok    = |hit;
   wire  [3:0]  mode       = ctrl_reg.mode;
   wire         fast       = is_fast(mode);
   wire         buffered   = fast; // RQ22
   wire [15:0]  wmask      = fixed_mask(mode); // RQ15
   wire [15:0]  wr_value   = pwdata[15:0] & wmask; // RQ15

   // Top selection.
   wire         mode_ctc_a = (mode == MODE_CLR_CMPA);
   wire         mode_ctc_c = (mode == MODE_CLR_CAPT);
   wire         top_cmp    = mode_ctc_a || (mode == MODE_FAST_CMP);
   wire         top_capt   = mode_ctc_c || (mode == MODE_FAST_CAP);
   wire [15:0]  top_val    = top_cmp  ? cmp_a_reg :                  // RQ5 RQ12
                             top_capt ? capt_reg  : fixed_mask(mode); // RQ12 RQ16

   // Counting.
   wire         tick       = tick_sync; // RQ25
   wire         at_top     = (count_reg == top_val) && (mode_ctc_a || mode_ctc_c || fast);
   wire         at_max     = (count_reg == TOP_MAX);
   wire         wrap_top   = tick && at_top && !block_reg; // RQ5 RQ7 RQ11 RQ12 RQ16 RQ24
   wire         wrap_max   = tick && at_max;                // RQ1 RQ7 RQ16
   wire [15:0]  count_inc  = count_reg + 16'h0001;
   wire [15:0]  count_next = wr_count ? pwdata[15:0] :                   // RQ4
                             wrap_top ? BOTTOM :
                             tick     ? count_inc : count_reg;            // RQ1
   wire         bottom_now = tick && fast && wrap_top;

   // Compare matches; a count write blocks the next timer cycle.
   wire         match_a    = tick && !block_reg && (count_reg == cmp_a_reg); // RQ21 RQ24
   wire         match_b    = tick && !block_reg && (count_reg == cmp_b_reg); // RQ21 RQ24

   // Flag events.
   wire         ev_ovf     = fast ? wrap_top : wrap_max; // RQ2 RQ10 RQ14
   wire         ev_cmpa    = match_a || (wrap_top && top_cmp);  // RQ6 RQ14
   wire         ev_capt    = (wrap_top && top_capt) || (capt_sync && !capt_prev); // RQ6 RQ14
   wire [3:0]   flag_set   = {ev_capt, match_b, ev_cmpa, ev_ovf};
   wire [3:0]   flag_clr   = (wr_flags ? pwdata[3:0] : 4'h0) | {3'h0, ack_sync}; // RQ3
   wire [3:0]   flags_next = flag_set | (flags_reg & ~flag_clr); // RQ2

   wire         wave_a_next = next_wave(wave_a_reg, fast, ctrl_reg.act_a, match_a, bottom_now);
   wire         wave_b_next = next_wave(wave_b_reg, fast, ctrl_reg.act_b, match_b, bottom_now);

   wire [31:0]  rd_value   = hit[0] ? {22'h0, ctrl_reg} :
                             hit[1] ? {16'h0, count_reg} :
                             hit[2] ? {16'h0, (buffered ? buf_a_reg : cmp_a_reg)} :
                             hit[3] ? {16'h0, (buffered ? buf_b_reg : cmp_b_reg)} :
                             hit[4] ? {16'h0, capt_reg} :
                             hit[5] ? {28'h0, flags_reg} :
                             hit[6] ? {cmp_b_reg, cmp_a_reg} : RESET_WORD;

   wire         pin_en_a   = ctrl_reg.dir_a && (ctrl_reg.act_a != ACT_NONE); // RQ9
   wire         pin_en_b   = ctrl_reg.dir_b && (ctrl_reg.act_b != ACT_NONE); // RQ9

   // Next register values.
   wire         block_next = wr_count || (block_reg && !tick); // RQ24
   wire         load_buf   = buffered && wrap_top; // RQ17 RQ22
   wire [15:0]  buf_a_next = wr_cmpa ? wr_value : buf_a_reg; // RQ17
   wire [15:0]  buf_b_next = wr_cmpb ? wr_value : buf_b_reg;
   wire [15:0]  cmp_a_next = (wr_cmpa && !buffered) ? wr_value : // RQ7 RQ22
                             load_buf ? buf_a_reg : cmp_a_reg;   // RQ17
   wire [15:0]  cmp_b_next = (wr_cmpb && !buffered) ? wr_value :
                             load_buf ? buf_b_reg : cmp_b_reg;   // RQ22
   wire [15:0]  capt_next  = wr_capt ? pwdata[15:0] : // RQ16
                             (!top_capt && capt_sync && !capt_prev) ? count_reg : capt_reg;
   wire [31:0]  prdata_next  = (acc_phase && !pwrite) ? rd_value : RESET_WORD;
   wire         pslverr_next = acc_phase && !addr_ok;
   tmr_ctrl_t   ctrl_next;
   tmr_pins_t   pins_next;
   assign ctrl_next = wr_ctrl ? tmr_ctrl_t'(pwdata[9:0]) : ctrl_reg;
   assign pins_next = {wave_a_reg, wave_b_reg, !pin_en_a, !pin_en_b};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_meta <= 1'b0;
         tick_sync <= 1'b0;
      end else begin
         tick_meta <= tick_en;
         tick_sync <= tick_meta;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
      end else begin
         ack_meta <= ovf_irq_ack;
         ack_sync <= ack_meta;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capt_meta <= 1'b0;
         capt_sync <= 1'b0;
         capt_prev <= 1'b0;
      end else begin
         capt_meta <= capture_event;
         capt_sync <= capt_meta;
         capt_prev <= capt_sync;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= BOTTOM;
      end else begin
         count_reg <= count_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         block_reg <= 1'b0;
      end else begin
         block_reg <= block_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_a_reg <= BOTTOM;
      end else begin
         buf_a_reg <= buf_a_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_b_reg <= BOTTOM;
      end else begin
         buf_b_reg <= buf_b_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_a_reg <= BOTTOM;
      end else begin
         cmp_a_reg <= cmp_a_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_b_reg <= BOTTOM;
      end else begin
         cmp_b_reg <= cmp_b_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capt_reg <= BOTTOM;
      end else begin
         capt_reg <= capt_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= 4'h0;
      end else begin
         flags_reg <= flags_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_a_reg <= 1'b0;
      end else begin
         wave_a_reg <= wave_a_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_b_reg <= 1'b0;
      end else begin
         wave_b_reg <= wave_b_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= RESET_WORD;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= acc_phase;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= pslverr_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_reg <= '{wave_a: 1'b0, wave_b: 1'b0, oe_n_a: 1'b1, oe_n_b: 1'b1};
      end else begin
         pins_reg <= pins_next;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign pins    = pins_reg;
endmodule

// file: rtl/tmr_pkg.sv
package tmr_pkg;
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_COUNT  = 12'h004;
   localparam logic [11:0] ADDR_CMPA   = 12'h008;
   localparam logic [11:0] ADDR_CMPB   = 12'h00c;
   localparam logic [11:0] ADDR_CAPT   = 12'h010;
   localparam logic [11:0] ADDR_FLAGS  = 12'h014;
   localparam logic [11:0] ADDR_ACTIVE = 12'h018;

   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_ACTA_LSB = 4;
   localparam int CTRL_ACTB_LSB = 6;
   localparam int CTRL_DIRA_BIT = 8;
   localparam int CTRL_DIRB_BIT = 9;

   localparam int FLAG_OVF_BIT  = 0;
   localparam int FLAG_CMPA_BIT = 1;
   localparam int FLAG_CMPB_BIT = 2;
   localparam int FLAG_CAPT_BIT = 3;

   localparam logic [3:0] MODE_NORMAL   = 4'h0;
   localparam logic [3:0] MODE_CLR_CMPA = 4'h4;
   localparam logic [3:0] MODE_FAST8    = 4'h5;
   localparam logic [3:0] MODE_FAST9    = 4'h6;
   localparam logic [3:0] MODE_FAST10   = 4'h7;
   localparam logic [3:0] MODE_CLR_CAPT = 4'hc;
   localparam logic [3:0] MODE_FAST_CAP = 4'he;
   localparam logic [3:0] MODE_FAST_CMP = 4'hf;

   localparam logic [15:0] TOP_MAX    = 16'hffff;
   localparam logic [15:0] TOP_FAST8  = 16'h00ff;
   localparam logic [15:0] TOP_FAST9  = 16'h01ff;
   localparam logic [15:0] TOP_FAST10 = 16'h03ff;
   localparam logic [15:0] BOTTOM     = 16'h0000;

   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR  = 2'h2;
   localparam logic [1:0] ACT_SET    = 2'h3;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   typedef struct packed {
      logic       dir_b;
      logic       dir_a;
      logic [1:0] act_b;
      logic [1:0] act_a;
      logic [3:0] mode;
   } tmr_ctrl_t;

   typedef struct packed {
      logic [11:0] addr;
      logic        write;
      logic [31:0] wdata;
   } tmr_apb_req_t;

   typedef struct packed {
      logic wave_a;
      logic wave_b;
      logic oe_n_a;
      logic oe_n_b;
   } tmr_pins_t;
endpackage

// file: sim/tmr_timer16_properties.sv
`timescale 1ns/1ns
module tmr_timer16_properties (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [11:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [3:0]         pstrb,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire tmr_pkg::tmr_pins_t pins
);
   import tmr_pkg::*;
   logic dir_a_reg;
   logic dir_b_reg;
   wire  ctrl_wr = psel && penable && pready && pwrite && paddr == ADDR_CTRL && pstrb[1:0] == 2'h3;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_a_reg <= 1'b0;
         dir_b_reg <= 1'b0;
      end else if (ctrl_wr) begin
         dir_a_reg <= pwdata[CTRL_DIRA_BIT];
         dir_b_reg <= pwdata[CTRL_DIRB_BIT];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after access phase");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel && penable && !pready))
      else $error("pready without access phase");
   a_err_decode: assert property (pready |-> pslverr == (paddr > ADDR_ACTIVE || paddr[1:0] != 2'h0))
      else $error("pslverr does not match address map");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero while idle");
   a_pin_a_dir: assert property (!pins.oe_n_a |-> dir_a_reg || $past(dir_a_reg) || $past(dir_a_reg, 2))
      else $error("pin A driven without direction bit");
   a_pin_b_dir: assert property (!pins.oe_n_b |-> dir_b_reg || $past(dir_b_reg) || $past(dir_b_reg, 2))
      else $error("pin B driven without direction bit");
endmodule
bind tmr_timer16 tmr_timer16_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pins(pins));

// file: sim/tmr_pin_model.sv
`timescale 1ns/1ns
module tmr_pin_model (
   input wire tmr_pkg::tmr_pins_t pins,
   output logic                   pad_a,
   output logic                   pad_b
);
   // Pads have pull-downs, so a released pin reads low.
   assign pad_a = pins.oe_n_a ? 1'b0 : pins.wave_a;
   assign pad_b = pins.oe_n_b ? 1'b0 : pins.wave_b;
endmodule

// file: sim/timer16_normal_clearmatch_fastpwm_tb.sv
`timescale 1ns/1ns
module timer16_normal_clearmatch_fastpwm_tb;
   import tmr_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        tick_en = 0, irq_ack = 0, pready, pslverr, err_q, pad_a, pad_b;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd_q;
   logic [3:0]  pstrb = 4'hf;
   tmr_pins_t   pins;
   int          fails = 0, samples_checked = 0, cyc = 0;
   always #25 pclk = ~pclk;
   tmr_timer16 DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tick_en(tick_en), .ovf_irq_ack(irq_ack), .capture_event(1'b0), .pins(pins));
   tmr_pin_model u_pads (.pins(pins), .pad_a(pad_a), .pad_b(pad_b));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, rd_q & m, e);
   endtask
   task automatic run(input int n);
      @(posedge pclk);
      tick_en <= 1'b1;
      repeat (n) @(posedge pclk);
      tick_en <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         close_out();
      end
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      chk("pad_a_reset", {31'h0, pad_a}, 32'h0);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_COUNT, 32'hffff);
      wr(ADDR_FLAGS, 32'hf);
      run(3);
      rc("count_wrap", ADDR_COUNT, 32'hffff, 32'h2);
      rc("ovf_normal", ADDR_FLAGS, 32'h1, 32'h1);
      @(posedge pclk);
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      repeat (4) @(posedge pclk);
      rc("ovf_ack", ADDR_FLAGS, 32'h1, 32'h0);
      $display("test normal done");
      wr(ADDR_CMPB, 32'h5);
      wr(ADDR_COUNT, 32'h5);
      wr(ADDR_FLAGS, 32'hf);
      run(1);
      rc("cmpb_blocked", ADDR_FLAGS, 32'h4, 32'h0);
      wr(ADDR_COUNT, 32'h4);
      run(2);
      rc("cmpb_match", ADDR_FLAGS, 32'h4, 32'h4);
      $display("test blocking done");
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_CTRL, i ? 32'h11c : 32'h114);
         wr(i ? ADDR_CAPT : ADDR_CMPA, 32'h3);
         wr(ADDR_COUNT, 32'h0);
         wr(ADDR_FLAGS, 32'hf);
         run(4);
         rc("ctc_clear", ADDR_COUNT, 32'hffff, 32'h0);
         rc("ctc_flag", ADDR_FLAGS, i ? 32'h8 : 32'h2, i ? 32'h8 : 32'h2);
         chk("ctc_pad", {31'h0, pad_a}, i ? 32'h0 : 32'h1);
      end
      wr(ADDR_CTRL, 32'h114);
      wr(ADDR_CMPA, 32'h2);
      wr(ADDR_COUNT, 32'h5);
      run(3);
      rc("ctc_missed", ADDR_COUNT, 32'hffff, 32'h8);
      wr(ADDR_COUNT, 32'hffff);
      wr(ADDR_FLAGS, 32'hf);
      run(2);
      rc("ctc_wrap", ADDR_COUNT, 32'hffff, 32'h1);
      rc("ovf_ctc", ADDR_FLAGS, 32'h1, 32'h1);
      $display("test clear_on_match done");
      wr(ADDR_CTRL, 32'h3f5);
      wr(ADDR_CMPA, 32'h1234);
      wr(ADDR_COUNT, 32'hfd);
      wr(ADDR_FLAGS, 32'hf);
      run(3);
      rc("fast_clear", ADDR_COUNT, 32'hffff, 32'h0);
      rc("ovf_fast", ADDR_FLAGS, 32'h1, 32'h1);
      rc("active_cmp", ADDR_ACTIVE, 32'hffffffff, 32'h0005_0034);
      chk("fast_pad_a", {31'h0, pad_a}, 32'h1);
      chk("fast_pad_b", {31'h0, pad_b}, 32'h1);
      wr(ADDR_CTRL, 32'h0f5);
      repeat (4) @(posedge pclk);
      chk("pad_released", {30'h0, pad_a, pad_b}, 32'h0);
      $display("test fast_pwm done");
      wr(ADDR_CTRL, 32'h3bf);
      wr(ADDR_CMPA, 32'h10);
      wr(ADDR_COUNT, 32'h33);
      wr(ADDR_FLAGS, 32'hf);
      run(8);
      rc("top_cmp_count", ADDR_COUNT, 32'hffff, 32'h6);
      rc("top_cmp_flags", ADDR_FLAGS, 32'h7, 32'h7);
      rc("top_cmp_active", ADDR_ACTIVE, 32'hffffffff, 32'h0005_0010);
      chk("top_cmp_pads", {30'h0, pad_a, pad_b}, 32'h1);
      $display("test fast_top done");
      rc("unmapped_data", 12'h01c, 32'hffffffff, 32'h0);
      chk("unmapped_err", {31'h0, err_q}, 32'h1);
      $display("test unmapped done");
      close_out();
   end
endmodule
